// ### design/nvs_host.sv
// Host-side controller that drives the nvSRAM pins and issues store/recall sequences
`include "nvs_cfg.svh"
// Contract
// [R1] Write strobe high on reads, low on writes
// [R2] Write strobe low before select: no data driven
// [R3] Six reads ending 0f0f start store
// [R4] Six reads ending 0f0e start recall
// [R5] All six in order, write strobe high
// [R6] Each step is a select-controlled read
// [R7] Power-up recall done within 550 us
// [R8] Stray access aborts the initiation sequence
// [R9] After store, no access until it ends
// [R10] After completion, sequence restarts at first
module nvs_host
  import nvs_pkg::*;
#(
  parameter int STORE_CYC = `NVS_CYC_STORE,
  parameter int RECALL_CYC = `NVS_CYC_RECALL,
  parameter int RESTORE_CYC = `NVS_CYC_RESTORE
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic req_valid,
  input wire nvs_req_t req,
  output logic req_ready,
  output logic [`NVS_DATA_W-1:0] rsp_rdata,
  output logic rsp_valid,
  output nvs_pins_t pins,
  output logic [`NVS_DATA_W-1:0] dq_out,
  output logic dq_oe_n,
  input wire logic [`NVS_DATA_W-1:0] dq_in
);

  typedef enum logic [2:0] {S_BOOT, S_IDLE, S_SETUP, S_PULSE, S_GAP, S_BUSY} nvs_state_t;

  nvs_state_t state_reg;
  nvs_op_t op_reg;
  logic [`NVS_CNT_W-1:0] cnt_reg;
  logic [2:0] step_reg;
  logic [`NVS_ADDR_W-1:0] addr_reg;
  logic [`NVS_DATA_W-1:0] wdata_reg;
  logic [`NVS_ADDR_W-1:0] seq_addr;
  logic seq_op;
  logic seq_last;

  assign seq_op = (op_reg == NVS_OP_STORE) || (op_reg == NVS_OP_RECALL);
  assign seq_last = seq_op && (step_reg == 3'h5);

  // Address for the current sequence step
  always_comb begin
    unique case (step_reg)
      3'h0: seq_addr = `NVS_SEQ_A0;
      3'h1: seq_addr = `NVS_SEQ_A1;
      3'h2: seq_addr = `NVS_SEQ_A2;
      3'h3: seq_addr = `NVS_SEQ_A3;
      3'h4: seq_addr = `NVS_SEQ_A4;
      default: seq_addr = (op_reg == NVS_OP_STORE) ? `NVS_SEQ_STORE : `NVS_SEQ_RECALL; // R3 R4
    endcase
  end

  // Main sequencer; sequence is one indivisible op so no foreign access can interleave
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_reg <= S_BOOT;
      cnt_reg <= `NVS_CNT_W'(RESTORE_CYC - 1);
      op_reg <= NVS_OP_READ;
      step_reg <= 3'h0;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      unique case (state_reg)
        S_BOOT: begin
          // Wait out power-up recall before first access
          if (cnt_reg == '0) state_reg <= S_IDLE; // R7
          else cnt_reg <= cnt_reg - 1'b1;
        end
        S_IDLE: begin
          if (req_valid) begin
            op_reg <= req.op;
            addr_reg <= req.addr;
            wdata_reg <= req.wdata;
            step_reg <= 3'h0; // R10
            cnt_reg <= `NVS_CNT_W'(`NVS_CYC_SETUP - 1);
            state_reg <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_reg == '0) begin
            cnt_reg <= `NVS_CNT_W'(`NVS_CYC_PULSE - 1);
            state_reg <= S_PULSE;
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        S_PULSE: begin
          if (cnt_reg == '0) begin
            cnt_reg <= `NVS_CNT_W'(`NVS_CYC_GAP - 1);
            state_reg <= S_GAP;
          end else cnt_reg <= cnt_reg - 1'b1;
        end
        S_GAP: begin
          if (cnt_reg != '0) cnt_reg <= cnt_reg - 1'b1;
          else if (seq_op && !seq_last) begin
            // Next step back to back, one select pulse each
            step_reg <= step_reg + 3'h1; // R5 R6
            cnt_reg <= `NVS_CNT_W'(`NVS_CYC_SETUP - 1);
            state_reg <= S_SETUP;
          end else if (seq_last) begin
            cnt_reg <= (op_reg == NVS_OP_STORE) ? `NVS_CNT_W'(STORE_CYC - 1) : `NVS_CNT_W'(RECALL_CYC - 1);
            state_reg <= S_BUSY; // R9
          end else state_reg <= S_IDLE;
        end
        S_BUSY: begin
          // Chip is deaf during store/recall; hold everything off
          if (cnt_reg == '0) begin
            step_reg <= 3'h0; // R10
            state_reg <= S_IDLE;
          end else cnt_reg <= cnt_reg - 1'b1; // R9
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // Pin drive: address and strobes registered; write strobe set before select falls
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pins <= '{chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1, addr: '0};
      dq_out <= '0;
      dq_oe_n <= 1'b1;
    end else begin
      pins.addr <= seq_op ? seq_addr : addr_reg;
      pins.chip_sel_n <= !(state_reg == S_PULSE && cnt_reg != '0); // R6
      // Strobe level fixed for the whole access
      pins.write_n <= !((state_reg == S_SETUP || state_reg == S_PULSE) && op_reg == NVS_OP_WRITE); // R1 R5
      pins.out_en_n <= !(state_reg == S_PULSE && op_reg == NVS_OP_READ);
      dq_out <= wdata_reg;
      dq_oe_n <= !((state_reg == S_SETUP || state_reg == S_PULSE) && op_reg == NVS_OP_WRITE); // R2
    end
  end

  // Read data captured at end of select pulse
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rsp_rdata <= '0;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (state_reg == S_PULSE && cnt_reg == 20'h00001 && op_reg == NVS_OP_READ) begin
        rsp_rdata <= dq_in;
        rsp_valid <= 1'b1;
      end
      req_ready <= (state_reg == S_IDLE) && !req_valid;
    end
  end

  // Cycles since reset, saturating; checks the power-up wait without trusting cnt_reg
  logic [`NVS_CNT_W-1:0] boot_age_reg;
  always_ff @(posedge clk_sys) begin
    if (!reset_n) boot_age_reg <= '0;
    else if (boot_age_reg != `NVS_CNT_W'(RESTORE_CYC)) boot_age_reg <= boot_age_reg + 1'b1;
  end

  // Checks
  property p_write_idle_on_read;
    @(posedge clk_sys) disable iff (!reset_n) (op_reg != NVS_OP_WRITE && state_reg != S_IDLE) |=> pins.write_n;
  endproperty
  a_write_idle_on_read: assert property (p_write_idle_on_read) else $error("write strobe low on non-write"); // R1
  property p_no_drive_on_read;
    @(posedge clk_sys) disable iff (!reset_n) !pins.out_en_n |-> dq_oe_n && pins.write_n;
  endproperty
  a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus contention on read"); // R2
  property p_seq_last_addr;
    @(posedge clk_sys) disable iff (!reset_n)
      (seq_last && state_reg == S_PULSE && op_reg == NVS_OP_STORE) |=> pins.addr == `NVS_SEQ_STORE;
  endproperty
  a_seq_last_addr: assert property (p_seq_last_addr) else $error("store address wrong"); // R3
  property p_recall_addr;
    @(posedge clk_sys) disable iff (!reset_n)
      (seq_last && state_reg == S_PULSE && op_reg == NVS_OP_RECALL) |=> pins.addr == `NVS_SEQ_RECALL;
  endproperty
  a_recall_addr: assert property (p_recall_addr) else $error("recall address wrong"); // R4
  property p_seq_no_write;
    @(posedge clk_sys) disable iff (!reset_n) (seq_op && state_reg != S_IDLE) |=> pins.write_n;
  endproperty
  a_seq_no_write: assert property (p_seq_no_write) else $error("write during sequence"); // R5
  property p_sel_pulse;
    @(posedge clk_sys) disable iff (!reset_n) $fell(pins.chip_sel_n) |-> $past(state_reg) == S_PULSE;
  endproperty
  a_sel_pulse: assert property (p_sel_pulse) else $error("select outside pulse"); // R6
  property p_boot_hold;
    @(posedge clk_sys) disable iff (!reset_n) state_reg == S_BOOT |-> pins.chip_sel_n && !req_ready;
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("access during power-up recall"); // R7
  property p_busy_quiet;
    @(posedge clk_sys) disable iff (!reset_n) state_reg == S_BUSY |=> pins.chip_sel_n && !rsp_valid;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("access during store"); // R9
  property p_busy_exit;
    @(posedge clk_sys) disable iff (!reset_n) (state_reg == S_BUSY && cnt_reg == '0) |=> step_reg == 3'h0;
  endproperty
  a_busy_exit: assert property (p_busy_exit) else $error("step not reset"); // R10
  property p_step_order;
    @(posedge clk_sys) disable iff (!reset_n) (state_reg == S_SETUP && $past(state_reg) == S_GAP) |-> seq_op;
  endproperty
  a_step_order: assert property (p_step_order) else $error("stray step"); // R8
  property p_boot_wait;
    @(posedge clk_sys) disable iff (!reset_n) !pins.chip_sel_n |-> boot_age_reg == `NVS_CNT_W'(RESTORE_CYC);
  endproperty
  a_boot_wait: assert property (p_boot_wait) else $error("select before power-up recall done"); // R7
  // Address must not move while select is low, or the step is lost
  property p_sel_addr_stable;
    @(posedge clk_sys) disable iff (!reset_n) (!pins.chip_sel_n && !$past(pins.chip_sel_n)) |-> $stable(pins.addr);
  endproperty
  a_sel_addr_stable: assert property (p_sel_addr_stable) else $error("address moved under select"); // R6
  property p_seq_no_drive;
    @(posedge clk_sys) disable iff (!reset_n) (seq_op && state_reg != S_IDLE) |=> dq_oe_n;
  endproperty
  a_seq_no_drive: assert property (p_seq_no_drive) else $error("data driven during sequence"); // R3
  c_boot_done: cover property (@(posedge clk_sys) state_reg == S_BOOT && cnt_reg == '0);
  c_store: cover property (@(posedge clk_sys) state_reg == S_BUSY && op_reg == NVS_OP_STORE);
  c_recall: cover property (@(posedge clk_sys) state_reg == S_BUSY && op_reg == NVS_OP_RECALL);
  c_read: cover property (@(posedge clk_sys) rsp_valid);
  c_write: cover property (@(posedge clk_sys) !pins.write_n && !pins.chip_sel_n);
endmodule

// ### design/nvs_cfg.svh
// Timing counts, sequence addresses and widths for the nvSRAM host controller
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH
`define NVS_ADDR_W 13
`define NVS_DATA_W 8
`define NVS_CLK_NS 10
`define NVS_SEQ_A0 13'h0000
`define NVS_SEQ_A1 13'h1555
`define NVS_SEQ_A2 13'h0aaa
`define NVS_SEQ_A3 13'h1fff
`define NVS_SEQ_A4 13'h10f0
`define NVS_SEQ_STORE 13'h0f0f
`define NVS_SEQ_RECALL 13'h0f0e
// Access phase lengths in ns (slowest speed grade)
`define NVS_T_SETUP_NS 10
`define NVS_T_PULSE_NS 60
`define NVS_T_GAP_NS 20
`define NVS_CYC_SETUP ((`NVS_T_SETUP_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_CYC_PULSE ((`NVS_T_PULSE_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_CYC_GAP ((`NVS_T_GAP_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
// Busy times in us: store, software recall, power-up recall
`define NVS_T_STORE_US 10000
`define NVS_T_RECALL_US 20
`define NVS_T_RESTORE_US 550
`define NVS_CYC_STORE (`NVS_T_STORE_US * 1000 / `NVS_CLK_NS)
`define NVS_CYC_RECALL (`NVS_T_RECALL_US * 1000 / `NVS_CLK_NS)
`define NVS_CYC_RESTORE (`NVS_T_RESTORE_US * 1000 / `NVS_CLK_NS)
`define NVS_CNT_W 20
`endif

// ### design/nvs_pkg.sv
// Types for the nvSRAM host controller
`include "nvs_cfg.svh"
package nvs_pkg;
  typedef enum logic [1:0] {NVS_OP_READ, NVS_OP_WRITE, NVS_OP_STORE, NVS_OP_RECALL} nvs_op_t;
  typedef struct packed {
    nvs_op_t op;
    logic [`NVS_ADDR_W-1:0] addr;
    logic [`NVS_DATA_W-1:0] wdata;
  } nvs_req_t;
  typedef struct packed {
    logic chip_sel_n;
    logic write_n;
    logic out_en_n;
    logic [`NVS_ADDR_W-1:0] addr;
  } nvs_pins_t;
endpackage

// ### testbench/nvs_dev_model.sv
// Behavioural model of the nvSRAM device driven by the host controller
`include "nvs_cfg.svh"
module nvs_dev_model
  import nvs_pkg::*;
#(
  parameter int STORE_NS = 400,
  parameter int RECALL_NS = 150,
  parameter int RESTORE_NS = 250
) (
  input wire nvs_pins_t pins,
  input wire logic [`NVS_DATA_W-1:0] dq_wire,
  output logic [`NVS_DATA_W-1:0] dq_q,
  output int store_cnt,
  output int recall_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sram [0:8191];
  logic [7:0] shadow [0:8191];
  logic [12:0] seq_addr [0:4] = '{`NVS_SEQ_A0, `NVS_SEQ_A1, `NVS_SEQ_A2, `NVS_SEQ_A3, `NVS_SEQ_A4};
  logic busy = 1'b1;
  logic wlow_at_sel = 1'b0;
  int step = 0;
  // Power-up recall keeps the part deaf for a while
  initial begin
    store_cnt = 0;
    recall_cnt = 0;
    dq_q = 8'h00;
    #(RESTORE_NS) busy = 1'b0;
  end
  // Sequence tracker; blocking on busy means input is ignored meanwhile
  always @(negedge pins.chip_sel_n) begin
    wlow_at_sel = !pins.write_n;
    if (busy) begin
    end else if (!pins.write_n) begin
      step = 0;
    end else if (step == 5 && pins.addr == `NVS_SEQ_STORE) begin
      busy = 1'b1;
      step = 0;
      store_cnt++;
      for (int i = 0; i < 8192; i++) shadow[i] = sram[i];
      #(STORE_NS) busy = 1'b0;
    end else if (step == 5 && pins.addr == `NVS_SEQ_RECALL) begin
      busy = 1'b1;
      step = 0;
      recall_cnt++;
      for (int i = 0; i < 8192; i++) sram[i] = shadow[i];
      #(RECALL_NS) busy = 1'b0;
    end else if (step < 5 && pins.addr == seq_addr[step]) begin
      step++;
    end else begin
      step = (pins.addr == `NVS_SEQ_A0) ? 1 : 0;
    end
  end
  // Write sampled 1 ns past each change, so edge ordering cannot corrupt it
  always @(pins or dq_wire) begin
    #1;
    if (!busy && !pins.chip_sel_n && !pins.write_n) sram[pins.addr] = dq_wire;
  end
  // Read drive; a released bus shows the inverse of its last value
  always @(pins or busy or wlow_at_sel) begin
    if (!busy && !pins.chip_sel_n && !pins.out_en_n && pins.write_n && !wlow_at_sel) dq_q = sram[pins.addr];
    else dq_q = ~dq_q;
  end
endmodule

// ### testbench/nvs_host_tb.sv
// Self-checking bench for the nvSRAM host controller
`include "nvs_cfg.svh"
module nvs_host_tb
  import nvs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  nvs_req_t req = '0;
  logic req_ready, rsp_valid, dq_oe_n;
  logic [7:0] rsp_rdata, dq_out, mdl_q;
  wire logic [7:0] dq_bus;
  nvs_pins_t pins;
  int bad_count = 0, compares = 0, cyc = 0, store_cnt, recall_cnt;
  // Host drive wins the shared data wire when enabled
  assign dq_bus = dq_oe_n ? mdl_q : dq_out;
  initial forever #5 clk_sys = ~clk_sys;
  nvs_host #(.STORE_CYC(50), .RECALL_CYC(20), .RESTORE_CYC(30)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
    .pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_bus));
  nvs_dev_model dev (.pins(pins), .dq_wire(dq_bus), .dq_q(mdl_q), .store_cnt(store_cnt), .recall_cnt(recall_cnt));
  task automatic check8(string nm, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  task automatic print_verdict();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Wait for idle, then hold the request over one taking edge
  task automatic issue(nvs_op_t op, logic [12:0] a, logic [7:0] d);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op: op, addr: a, wdata: d};
    @(posedge clk_sys);
    req_valid <= 1'b0;
  endtask
  task automatic read_chk(string nm, logic [12:0] a, logic [7:0] e);
    int n;
    n = 0;
    issue(NVS_OP_READ, a, 8'h00);
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check8("rsp_valid", 8'h01, 8'(rsp_valid));
    check8(nm, e, rsp_rdata);
  endtask
  // Plain writes and reads right after boot, one on a sequence address
  task automatic t_rw();
    repeat (4) @(posedge clk_sys);
    #1;
    check8("ready_boot", 8'h00, 8'(req_ready));
    issue(NVS_OP_WRITE, 13'h0123, 8'ha5);
    issue(NVS_OP_WRITE, 13'h1555, 8'h3c);
    read_chk("rd_0123", 13'h0123, 8'ha5);
    read_chk("rd_1555", 13'h1555, 8'h3c);
  endtask
  // Store, overwrite, recall restores; a second store proves the tracker rearmed
  task automatic t_store_recall();
    issue(NVS_OP_STORE, 13'h0000, 8'h00);
    read_chk("after_store", 13'h0123, 8'ha5);
    check8("store_cnt", 8'h01, 8'(store_cnt));
    issue(NVS_OP_WRITE, 13'h0123, 8'hc3);
    read_chk("new_data", 13'h0123, 8'hc3);
    issue(NVS_OP_RECALL, 13'h0000, 8'h00);
    read_chk("recalled", 13'h0123, 8'ha5);
    check8("recall_cnt", 8'h01, 8'(recall_cnt));
    issue(NVS_OP_STORE, 13'h0000, 8'h00);
    read_chk("seq_cell", 13'h1555, 8'h3c);
    check8("store_cnt2", 8'h02, 8'(store_cnt));
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_rw();
    t_store_recall();
    print_verdict();
  end
  // Ceiling well above the hundred-odd cycles the longest operation, a store, needs
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      print_verdict();
    end
  end
endmodule
